/* File: rtl/brake_seq_pkg.sv */
// Purpose: shared constants for the brake sequencer and overflow alarm
// Assumes: 40 MHz control clock
// Notes:   parameter object indices are the byte-free object numbers
`default_nettype none
package brake_seq_pkg;
  // parameter object indices
  localparam logic [15:0] IDX_OVF_LIMIT     = 16'h335C;
  localparam logic [15:0] IDX_ON_DELAY      = 16'h335D;
  localparam logic [15:0] IDX_OFF_DELAY     = 16'h335E;
  localparam logic [15:0] IDX_SPD_THRESH    = 16'h335F;
  localparam logic [15:0] IDX_BRK_WAIT      = 16'h3360;
  // reset values
  localparam logic [31:0] RST_OVF_LIMIT     = 32'h0280_0000;
  localparam logic [15:0] RST_ON_DELAY      = 16'h0000;
  localparam logic [15:0] RST_OFF_DELAY     = 16'h0000;
  localparam logic [15:0] RST_SPD_THRESH    = 16'h0064;
  localparam logic [15:0] RST_BRK_WAIT      = 16'h0032;
  // timing
  localparam int          CLK_PERIOD_NS     = 25;
  localparam int          MS_NS             = 1000000;
  localparam int          CYCLES_PER_MS     = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MS_PER_STEP       = 16'h000A;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_BRAKE_FIRST,
    ST_ON_MOTOR_FIRST,
    ST_RUN,
    ST_OFF_POWER_DELAY,
    ST_OFF_BRAKE_WAIT
  } seq_state_t;
endpackage : brake_seq_pkg
`default_nettype wire

/* File: rtl/ms_tick_gen.sv */
// Purpose: one-cycle millisecond enable pulse from the control clock
// Assumes: clear restarts the period so a new wait starts on a full ms
// Notes:   period set by CYCLES parameter
`default_nettype none
module ms_tick_gen #(
  parameter int CYCLES = brake_seq_pkg::CYCLES_PER_MS
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_d;
  logic        tick_q;

  always_comb begin
    tick_d = 1'b0;
    if (clear_i) begin
      cnt_d = 32'h0000_0000;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_d  = 32'h0000_0000;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule : ms_tick_gen
`default_nettype wire

/* File: rtl/brake_sequencer_overflow_alarm.sv */
// Purpose: holding brake sequencing and deviation counter overflow alarm
// Assumes: brake_hold_output high means brake released (coil powered)
// Notes:   parameter objects written through the indexed parameter port
// Summary of operation
// - alarm flags when deviation magnitude exceeds the overflow limit
// - brake delays and thresholds apply only when brake output is allocated
// - positive on-delay: brake output on, wait ms, then excite motor
// - negative on-delay: excite motor, wait magnitude ms, then brake output on
// - servo-off while stopped drops brake output at once
// - servo-off while stopped keeps motor power for off-delay times 10 ms
// - servo-off while moving acts on brake once speed below threshold
// - servo-off while moving acts on brake once wait time times 10 ms exceeded
// - whichever of speed or time condition comes first triggers the brake
`default_nettype none
module brake_sequencer_overflow_alarm #(
  parameter int CYCLES_PER_MS = brake_seq_pkg::CYCLES_PER_MS
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        servo_on_i,
  input  wire logic        brake_allocated_i,
  input  wire logic [15:0] motor_speed_i,
  input  wire logic [31:0] deviation_i,
  input  wire logic        alarm_clear_i,
  input  wire logic        param_we_i,
  input  wire logic [15:0] param_index_i,
  input  wire logic [31:0] param_wdata_i,
  output logic [31:0]      param_rdata_o,
  output logic             brake_hold_output_o,
  output logic             motor_excite_o,
  output logic             overflow_alarm_o
);
  logic [31:0] ovf_limit_q, ovf_limit_d;
  logic [15:0] on_delay_q, on_delay_d;
  logic [15:0] off_delay_q, off_delay_d;
  logic [15:0] spd_thresh_q, spd_thresh_d;
  logic [15:0] brk_wait_q, brk_wait_d;
  logic [31:0] rdata_q, rdata_d;
  brake_seq_pkg::seq_state_t state_q, state_d;
  logic [15:0] ms_cnt_q, ms_cnt_d;
  logic        brake_q, brake_d;
  logic        excite_q, excite_d;
  logic        alarm_q, alarm_d;
  logic        tick;
  logic        tmr_clear;
  logic [31:0] dev_abs;
  logic [15:0] spd_abs;
  logic [15:0] on_mag;
  logic        slow;

  ms_tick_gen #(.CYCLES(CYCLES_PER_MS)) u_tick (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .clear_i (tmr_clear),
    .tick_o  (tick)
  );

  assign dev_abs = deviation_i[31] ? (32'h0000_0000 - deviation_i) : deviation_i;
  assign spd_abs = motor_speed_i[15] ? (16'h0000 - motor_speed_i) : motor_speed_i;
  assign on_mag  = on_delay_q[15] ? (16'h0000 - on_delay_q) : on_delay_q;
  assign slow    = spd_abs < spd_thresh_q;

  // parameter objects
  always_comb begin
    ovf_limit_d  = ovf_limit_q;
    on_delay_d   = on_delay_q;
    off_delay_d  = off_delay_q;
    spd_thresh_d = spd_thresh_q;
    brk_wait_d   = brk_wait_q;
    if (param_we_i) begin
      if (param_index_i == brake_seq_pkg::IDX_OVF_LIMIT) begin
        ovf_limit_d = param_wdata_i;
      end else if (param_index_i == brake_seq_pkg::IDX_ON_DELAY) begin
        on_delay_d = param_wdata_i[15:0];
      end else if (param_index_i == brake_seq_pkg::IDX_OFF_DELAY) begin
        off_delay_d = param_wdata_i[15:0];
      end else if (param_index_i == brake_seq_pkg::IDX_SPD_THRESH) begin
        spd_thresh_d = param_wdata_i[15:0];
      end else if (param_index_i == brake_seq_pkg::IDX_BRK_WAIT) begin
        brk_wait_d = param_wdata_i[15:0];
      end
    end
    if (param_index_i == brake_seq_pkg::IDX_OVF_LIMIT) begin
      rdata_d = ovf_limit_q;
    end else if (param_index_i == brake_seq_pkg::IDX_ON_DELAY) begin
      rdata_d = {16'h0000, on_delay_q};
    end else if (param_index_i == brake_seq_pkg::IDX_OFF_DELAY) begin
      rdata_d = {16'h0000, off_delay_q};
    end else if (param_index_i == brake_seq_pkg::IDX_SPD_THRESH) begin
      rdata_d = {16'h0000, spd_thresh_q};
    end else if (param_index_i == brake_seq_pkg::IDX_BRK_WAIT) begin
      rdata_d = {16'h0000, brk_wait_q};
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovf_limit_q  <= brake_seq_pkg::RST_OVF_LIMIT;
      on_delay_q   <= brake_seq_pkg::RST_ON_DELAY;
      off_delay_q  <= brake_seq_pkg::RST_OFF_DELAY;
      spd_thresh_q <= brake_seq_pkg::RST_SPD_THRESH;
      brk_wait_q   <= brake_seq_pkg::RST_BRK_WAIT;
      rdata_q      <= 32'h0000_0000;
    end else begin
      ovf_limit_q  <= ovf_limit_d;
      on_delay_q   <= on_delay_d;
      off_delay_q  <= off_delay_d;
      spd_thresh_q <= spd_thresh_d;
      brk_wait_q   <= brk_wait_d;
      rdata_q      <= rdata_d;
    end
  end

  // overflow alarm, set wins over clear
  always_comb begin
    alarm_d = alarm_q;
    if (alarm_clear_i) begin
      alarm_d = 1'b0;
    end
    if (dev_abs > ovf_limit_q) begin
      alarm_d = 1'b1;
    end
  end

  // brake sequencer
  always_comb begin
    state_d   = state_q;
    ms_cnt_d  = tick ? (ms_cnt_q + 16'h0001) : ms_cnt_q;
    tmr_clear = 1'b0;
    case (state_q)
      brake_seq_pkg::ST_OFF: begin
        if (servo_on_i) begin
          tmr_clear = 1'b1;
          ms_cnt_d  = 16'h0000;
          if (!brake_allocated_i || on_delay_q == 16'h0000) begin
            state_d = brake_seq_pkg::ST_RUN;
          end else if (!on_delay_q[15]) begin
            state_d = brake_seq_pkg::ST_ON_BRAKE_FIRST;
          end else begin
            state_d = brake_seq_pkg::ST_ON_MOTOR_FIRST;
          end
        end
      end
      brake_seq_pkg::ST_ON_BRAKE_FIRST,
      brake_seq_pkg::ST_ON_MOTOR_FIRST: begin
        if (!servo_on_i) begin
          state_d = brake_seq_pkg::ST_OFF;
        end else if (ms_cnt_q >= on_mag) begin
          state_d = brake_seq_pkg::ST_RUN;
        end
      end
      brake_seq_pkg::ST_RUN: begin
        if (!servo_on_i) begin
          tmr_clear = 1'b1;
          ms_cnt_d  = 16'h0000;
          if (!brake_allocated_i) begin
            state_d = brake_seq_pkg::ST_OFF;
          end else if (slow) begin
            state_d = brake_seq_pkg::ST_OFF_POWER_DELAY;
          end else begin
            state_d = brake_seq_pkg::ST_OFF_BRAKE_WAIT;
          end
        end
      end
      brake_seq_pkg::ST_OFF_POWER_DELAY: begin
        if (servo_on_i) begin
          state_d = brake_seq_pkg::ST_RUN;
        end else if (ms_cnt_q >= 16'(off_delay_q * brake_seq_pkg::MS_PER_STEP)) begin
          state_d = brake_seq_pkg::ST_OFF;
        end
      end
      brake_seq_pkg::ST_OFF_BRAKE_WAIT: begin
        if (servo_on_i) begin
          state_d = brake_seq_pkg::ST_RUN;
        end else if (slow ||
                     ms_cnt_q > 16'(brk_wait_q * brake_seq_pkg::MS_PER_STEP)) begin
          state_d = brake_seq_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = brake_seq_pkg::ST_OFF;
      end
    endcase
    brake_d  = brake_allocated_i &&
               (state_d == brake_seq_pkg::ST_ON_BRAKE_FIRST ||
                state_d == brake_seq_pkg::ST_RUN ||
                state_d == brake_seq_pkg::ST_OFF_BRAKE_WAIT);
    excite_d = state_d == brake_seq_pkg::ST_ON_MOTOR_FIRST ||
               state_d == brake_seq_pkg::ST_RUN ||
               state_d == brake_seq_pkg::ST_OFF_POWER_DELAY ||
               state_d == brake_seq_pkg::ST_OFF_BRAKE_WAIT;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q  <= brake_seq_pkg::ST_OFF;
      ms_cnt_q <= 16'h0000;
      brake_q  <= 1'b0;
      excite_q <= 1'b0;
      alarm_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      ms_cnt_q <= ms_cnt_d;
      brake_q  <= brake_d;
      excite_q <= excite_d;
      alarm_q  <= alarm_d;
    end
  end

  assign param_rdata_o       = rdata_q;
  assign brake_hold_output_o = brake_q;
  assign motor_excite_o      = excite_q;
  assign overflow_alarm_o    = alarm_q;

  // checks
  sequence s_stopped_off;
    state_q == brake_seq_pkg::ST_RUN && !servo_on_i && slow && brake_allocated_i;
  endsequence

  sequence s_moving_off;
    state_q == brake_seq_pkg::ST_RUN && !servo_on_i && !slow && brake_allocated_i;
  endsequence

  a_overflow_sets: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    dev_abs > ovf_limit_q |=> overflow_alarm_o)
    else $error("overflow not flagged");
  a_alarm_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    overflow_alarm_o && !alarm_clear_i |=> overflow_alarm_o)
    else $error("alarm dropped without clear");
  a_unalloc_no_brake: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !$past(brake_allocated_i) |-> !brake_hold_output_o)
    else $error("brake driven while unallocated");
  a_brake_before_excite: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == brake_seq_pkg::ST_ON_BRAKE_FIRST |-> brake_hold_output_o && !motor_excite_o)
    else $error("positive delay order wrong");
  a_excite_before_brake: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == brake_seq_pkg::ST_ON_MOTOR_FIRST |-> motor_excite_o && !brake_hold_output_o)
    else $error("negative delay order wrong");
  a_stop_brake_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_stopped_off |=> !brake_hold_output_o && motor_excite_o)
    else $error("brake not dropped at stopped servo off");
  a_power_delay_end: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == brake_seq_pkg::ST_OFF_POWER_DELAY && !servo_on_i &&
    ms_cnt_q >= 16'(off_delay_q * brake_seq_pkg::MS_PER_STEP) |=> !motor_excite_o)
    else $error("power not removed after delay");
  a_slow_brake: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == brake_seq_pkg::ST_OFF_BRAKE_WAIT && !servo_on_i && slow
    |=> !brake_hold_output_o && !motor_excite_o)
    else $error("speed condition ignored");
  a_wait_brake: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == brake_seq_pkg::ST_OFF_BRAKE_WAIT && !servo_on_i &&
    ms_cnt_q > 16'(brk_wait_q * brake_seq_pkg::MS_PER_STEP) |=> !brake_hold_output_o)
    else $error("time condition ignored");
  a_moving_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_moving_off |=> brake_hold_output_o && motor_excite_o)
    else $error("moving servo off dropped outputs");
  a_reon_cancel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_q == brake_seq_pkg::ST_OFF_POWER_DELAY ||
     state_q == brake_seq_pkg::ST_OFF_BRAKE_WAIT) && servo_on_i && brake_allocated_i
    |=> state_q == brake_seq_pkg::ST_RUN && brake_hold_output_o && motor_excite_o)
    else $error("servo on did not cancel");
endmodule : brake_sequencer_overflow_alarm
`default_nettype wire

/* File: sim/motor_plant_model.sv */
// Purpose: brake driver and motor power stage seen from the sequencer
// Assumes: speed ramps toward the bench target only while excited
// Notes:   engaged brake with no excitation stops the shaft at once
`default_nettype none
module motor_plant_model (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        excite_i,
  input  wire logic        brake_hold_i,
  input  wire logic [15:0] spin_i,
  output logic      [15:0] speed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tgt;
  assign tgt = excite_i ? spin_i : 16'h0000;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) speed_o <= 16'h0000;
    else if (!excite_i && !brake_hold_i) speed_o <= 16'h0000;
    else if (speed_o > tgt + 16'h0008) speed_o <= speed_o - 16'h0008;
    else if (speed_o + 16'h0008 < tgt) speed_o <= speed_o + 16'h0008;
    else speed_o <= tgt;
  end
endmodule : motor_plant_model
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the brake sequencer and overflow alarm
// Assumes: ten clock cycles per ms in simulation
// Notes:   plant model feeds speed back from excitation and brake
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_b, son, alloc, clr, we, brake, excite, alarm;
  logic [15:0] spin, speed, idx;
  logic [31:0] dev, wd, rdata;
  int          error_cnt, checks_done, cyc;
  brake_sequencer_overflow_alarm #(.CYCLES_PER_MS(10)) brake_sequencer_overflow_alarm_i (
    .clock_i(clock), .rst_b_i(rst_b), .servo_on_i(son), .brake_allocated_i(alloc),
    .motor_speed_i(speed), .deviation_i(dev), .alarm_clear_i(clr), .param_we_i(we),
    .param_index_i(idx), .param_wdata_i(wd), .param_rdata_o(rdata),
    .brake_hold_output_o(brake), .motor_excite_o(excite), .overflow_alarm_o(alarm));
  motor_plant_model motor_plant_model_i (
    .clock_i(clock), .rst_b_i(rst_b), .excite_i(excite), .brake_hold_i(brake),
    .spin_i(spin), .speed_o(speed));
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic at(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : at
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge clock);
    we <= 1'b1;
    idx <= i;
    wd <= d;
    @(posedge clock);
    we <= 1'b0;
  endtask : wr
  task automatic sv(input logic v);
    @(posedge clock);
    son <= v;
  endtask : sv
  task automatic both(input logic b, input logic e, input string m);
    chk(brake === b && excite === e, m);
  endtask : both
  task automatic t_regs;
    logic [15:0] ix [5] = '{16'h335C, 16'h335D, 16'h335E, 16'h335F, 16'h3360};
    logic [31:0] ex [5] = '{32'h0280_0000, 32'h0, 32'h0, 32'h64, 32'h32};
    for (int k = 0; k < 5; k++) begin
      @(posedge clock);
      idx <= ix[k];
      at(2);
      chk(rdata === ex[k], "reset value");
    end
    @(posedge clock);
    idx <= 16'h3361;
    at(2);
    chk(rdata === 32'h0, "unknown index");
    wr(16'h335F, 32'h32);
    at(2);
    chk(rdata === 32'h32, "readback");
    wr(16'h335F, 32'h64);
  endtask : t_regs
  task automatic t_ovf;
    wr(16'h335C, 32'h64);
    dev <= 32'h64;
    at(3);
    chk(alarm === 1'b0, "alarm at limit");
    @(posedge clock);
    dev <= 32'hFFFF_FF9B;
    at(2);
    chk(alarm === 1'b1, "alarm over limit");
    @(posedge clock);
    dev <= 32'h0;
    clr <= 1'b1;
    at(2);
    chk(alarm === 1'b0, "alarm clear");
    @(posedge clock);
    clr <= 1'b0;
  endtask : t_ovf
  task automatic t_on(input logic [31:0] d, input logic b1, input logic e1);
    wr(16'h335D, d);
    sv(1'b1);
    at(2);
    both(b1, e1, "on first step");
    at(15);
    both(b1, e1, "on mid wait");
    at(25);
    both(1'b1, 1'b1, "on done");
    sv(1'b0);
    at(5);
  endtask : t_on
  task automatic t_unalloc;
    @(posedge clock);
    alloc <= 1'b0;
    sv(1'b1);
    at(2);
    both(1'b0, 1'b1, "unallocated on");
    sv(1'b0);
    at(3);
    chk(excite === 1'b0, "unallocated off");
    @(posedge clock);
    alloc <= 1'b1;
  endtask : t_unalloc
  task automatic t_off_stop;
    wr(16'h335D, 32'h0);
    wr(16'h335E, 32'h3);
    sv(1'b1);
    at(3);
    sv(1'b0);
    at(2);
    both(1'b0, 1'b1, "stop brake drop");
    at(290);
    chk(excite === 1'b1, "power held");
    at(30);
    chk(excite === 1'b0, "power removed");
    sv(1'b1);
    at(3);
    sv(1'b0);
    at(2);
    both(1'b0, 1'b1, "second stop brake drop");
    sv(1'b1);
    at(2);
    both(1'b1, 1'b1, "power delay cancel");
  endtask : t_off_stop
  task automatic t_off_spd;
    spin <= 16'h01F4;
    sv(1'b1);
    at(80);
    sv(1'b0);
    at(50);
    both(1'b1, 1'b1, "moving held");
    spin <= 16'h0;
    at(80);
    both(1'b0, 1'b0, "slow brake");
  endtask : t_off_spd
  task automatic t_off_time;
    wr(16'h3360, 32'hA);
    spin <= 16'h01F4;
    sv(1'b1);
    at(80);
    sv(1'b0);
    at(600);
    sv(1'b1);
    at(2);
    both(1'b1, 1'b1, "servo on cancels");
    sv(1'b0);
    at(950);
    both(1'b1, 1'b1, "timer restarted");
    at(100);
    both(1'b0, 1'b0, "time brake");
    spin <= 16'h0;
  endtask : t_off_time
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {rst_b, son, clr, we} = '0;
    alloc = 1'b1;
    {spin, idx} = '0;
    {dev, wd} = '0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_ovf();
    t_on(32'h3, 1'b1, 1'b0);
    t_on(32'hFFFE, 1'b0, 1'b1);
    t_unalloc();
    t_off_stop();
    t_off_spd();
    t_off_time();
    close_out();
  end
endmodule : testbench
`default_nettype wire
